// ==== design/prps_pkg.sv ====
// Shared constants, types and register map of the reset and power-down sequencer
package prps_pkg;

	// Clock and minimum hardware reset pulse
	localparam int CLK_PERIOD_NS = 100;
	localparam int RST_MIN_NS    = 1000;
	localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register byte offsets
	localparam logic [7:0] OFF_PINCFG = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_MASK   = 8'h08;
	localparam logic [7:0] OFF_STATE  = 8'h0C;
	localparam logic [7:0] OFF_REGPWR = 8'hD0;

	// Field positions
	localparam int PINCFG_IRQ_BIT  = 0;
	localparam int REGPWR_OFF_BIT  = 0;
	localparam int STATE_READY_BIT = 0;
	localparam int STATE_PWDN_BIT  = 1;
	localparam int STATE_ROLE_BIT  = 2;
	localparam int STATE_IRQ_BIT   = 3;
	localparam int STATE_STRAP_LSB = 8;

	// Values after reset
	localparam logic        PINCFG_RST = 1'b0;
	localparam logic [15:0] REGPWR_RST = 16'h0000;
	localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

	typedef enum logic [1:0] {
		SEQ_HOLD,
		SEQ_SAMPLE,
		SEQ_RUN
	} prps_seq_e;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} prps_avl_req_s;

endpackage

// ==== design/prps_reset_filter.sv ====
// Qualifies the hardware reset pin against its minimum low time
`timescale 1ns/100ps
`default_nettype none
module prps_reset_filter #(
	parameter int MIN_CYC = prps_pkg::RST_MIN_CYC
) (
	input  wire logic clk,          // Device clock
	input  wire logic nrst,         // Synchronous reset, low active
	input  wire logic ce,           // Clock enable
	input  wire logic hwResetN,     // Hardware reset pin, low active
	output var  logic resetActive   // High while a qualified reset is held
);

	localparam int CW = $clog2(MIN_CYC + 1);

	logic [CW-1:0] lowCnt_ff;
	logic          active_ff;
	wire           reached = (lowCnt_ff >= CW'(MIN_CYC - 1));

	// Short glitches never reach the count, so they are ignored
	always_ff @(posedge clk) begin
		if (!nrst) begin
			lowCnt_ff <= '0;
			active_ff <= 1'b0;
		end else if (ce) begin
			lowCnt_ff <= hwResetN ? '0 : (reached ? lowCnt_ff : lowCnt_ff + CW'(1));
			active_ff <= !hwResetN && (reached || active_ff);
		end
	end

	assign resetActive = active_ff;

	AST_MIN_LOW: assert property (@(posedge clk) disable iff (!nrst || !ce)
		$rose(active_ff) |-> (lowCnt_ff >= CW'(MIN_CYC - 1)) && $past(!hwResetN))
		else $error("reset qualified before minimum low time");

endmodule
`default_nettype wire

// ==== design/prps_sequencer.sv ====
// Reset, strap capture, shared interrupt/power-down pin and regulator control
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module prps_sequencer #(
	parameter int IRQ_W   = 4,  // Interrupt event sources
	parameter int STRAP_W = 5   // Strap pins
) (
	input  wire logic                    clk,              // Device clock, 10 MHz
	input  wire logic                    nrst,             // Synchronous reset, low active
	input  wire logic                    ce,               // Clock enable, freezes all state
	input  wire logic                    hwResetN,         // Hardware reset pin, low active
	input  wire logic [STRAP_W-1:0]      strapIn,          // Strap pin levels
	input  wire logic [IRQ_W-1:0]        irqEvent,         // Interrupt event pulses
	input  wire logic                    irqOrSleepPinIn,  // Shared pin level
	output logic                         irqOrSleepPinOut, // Shared pin drive value
	output logic                         irqOrSleepPinOeN, // Shared pin enable, low drives
	input  wire prps_pkg::prps_avl_req_s avlReq,           // Avalon request
	output logic [31:0]                  avlReaddata,      // Avalon read data
	output logic                         avlWaitrequest,   // Avalon wait request
	output logic [STRAP_W-1:0]           strapCfg,         // Latched strap options
	output logic                         deviceReady,      // Reset sequence complete
	output logic                         powerDown,        // Device in power-down
	output logic                         regulatorOff,     // Internal regulator off
	output logic                         irq               // Interrupt, high active
);

	prps_pkg::prps_seq_e  state_ff;
	prps_pkg::prps_seq_e  nxt_state;
	logic                 ack_ff;
	logic [31:0]          rdata_ff;
	logic                 pinIsIrq_ff;
	logic [15:0]          regPwr_ff;
	logic [IRQ_W-1:0]     status_ff;
	logic [IRQ_W-1:0]     mask_ff;
	logic [IRQ_W-1:0]     nxt_status;
	logic [STRAP_W-1:0]   strap_ff;
	logic                 powerDown_ff;
	logic                 irq_ff;
	logic                 hwRstActive;

	prps_reset_filter #(
		.MIN_CYC (prps_pkg::RST_MIN_CYC)
	) u_filter (
		.clk         (clk),
		.nrst        (nrst),
		.ce          (ce),
		.hwResetN    (hwResetN),
		.resetActive (hwRstActive)
	);

	// Sequence: hold while reset, one sampling cycle, then run
	wire clrRegs = hwRstActive || (state_ff == prps_pkg::SEQ_HOLD);
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			prps_pkg::SEQ_HOLD:   nxt_state = hwRstActive ? prps_pkg::SEQ_HOLD : prps_pkg::SEQ_SAMPLE;
			prps_pkg::SEQ_SAMPLE: nxt_state = hwRstActive ? prps_pkg::SEQ_HOLD : prps_pkg::SEQ_RUN;
			prps_pkg::SEQ_RUN:    nxt_state = hwRstActive ? prps_pkg::SEQ_HOLD : prps_pkg::SEQ_RUN;
			default:              nxt_state = prps_pkg::SEQ_HOLD;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_ff <= prps_pkg::SEQ_HOLD;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	// Straps track the pins while reset holds and in the sampling cycle, and freeze once the sequence runs
	wire running  = (state_ff == prps_pkg::SEQ_RUN);
	wire sampling = !running;
	always_ff @(posedge clk) begin
		if (ce && (sampling || !nrst)) begin
			strap_ff <= strapIn;
		end
	end

	// Avalon slave: one wait state on every access
	wire req      = avlReq.read || avlReq.write;
	wire accept   = req && ack_ff && ce;
	wire wrAccept = accept && avlReq.write;
	wire hitPin   = (avlReq.address == prps_pkg::OFF_PINCFG);
	wire hitStat  = (avlReq.address == prps_pkg::OFF_STATUS);
	wire hitMask  = (avlReq.address == prps_pkg::OFF_MASK);
	wire hitState = (avlReq.address == prps_pkg::OFF_STATE);
	wire hitPwr   = (avlReq.address == prps_pkg::OFF_REGPWR);
	wire be0      = avlReq.byteenable[0];
	wire be1      = avlReq.byteenable[1];

	assign avlWaitrequest = req && !(ack_ff && ce);

	wire [STRAP_W+7:0] stateWord = {strap_ff, 4'h0, irq_ff, pinIsIrq_ff, powerDown_ff, running};
	wire [31:0] rdMux =
		hitPin   ? 32'(pinIsIrq_ff) :
		hitStat  ? 32'(status_ff) :
		hitMask  ? 32'(mask_ff) :
		hitState ? 32'(stateWord) :
		hitPwr   ? 32'(regPwr_ff) :
		prps_pkg::RDATA_NONE;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ack_ff   <= 1'b0;
			rdata_ff <= prps_pkg::RDATA_NONE;
		end else if (ce) begin
			ack_ff <= req && !ack_ff;
			if (avlReq.read && !ack_ff) begin
				rdata_ff <= rdMux;
			end
		end
	end

	assign avlReaddata = rdata_ff;

	// Software registers; hardware reset clears them all
	wire wrPin  = wrAccept && hitPin && be0;
	wire wrMask = wrAccept && hitMask && be0;
	wire wrStat = wrAccept && hitStat && be0;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pinIsIrq_ff <= prps_pkg::PINCFG_RST;
			mask_ff     <= '0;
			regPwr_ff   <= prps_pkg::REGPWR_RST;
		end else if (ce) begin
			if (clrRegs) begin
				pinIsIrq_ff <= prps_pkg::PINCFG_RST;
				mask_ff     <= '0;
				regPwr_ff   <= prps_pkg::REGPWR_RST;
			end else begin
				if (wrPin) begin
					pinIsIrq_ff <= avlReq.writedata[prps_pkg::PINCFG_IRQ_BIT];
				end
				if (wrMask) begin
					mask_ff <= avlReq.writedata[IRQ_W-1:0];
				end
				if (wrAccept && hitPwr && be0) begin
					regPwr_ff[7:0] <= avlReq.writedata[7:0];
				end
				if (wrAccept && hitPwr && be1) begin
					regPwr_ff[15:8] <= avlReq.writedata[15:8];
				end
			end
		end
	end

	// Sticky status, write one to clear; a new event beats the clear
	wire [IRQ_W-1:0] clrMask = wrStat ? avlReq.writedata[IRQ_W-1:0] : '0;
	always_comb begin
		nxt_status = (status_ff & ~clrMask) | irqEvent;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			status_ff    <= '0;
			irq_ff       <= 1'b0;
			powerDown_ff <= 1'b0;
		end else if (ce) begin
			status_ff    <= clrRegs ? '0 : nxt_status;
			irq_ff       <= |(status_ff & mask_ff);
			powerDown_ff <= running && !pinIsIrq_ff && !irqOrSleepPinIn;
		end
	end

	// Open drain: only ever drives low, never high
	assign irqOrSleepPinOut = 1'b0;
	assign irqOrSleepPinOeN = !(pinIsIrq_ff && irq_ff);
	assign irq              = irq_ff;
	assign powerDown        = powerDown_ff;
	assign regulatorOff     = regPwr_ff[prps_pkg::REGPWR_OFF_BIT];
	assign strapCfg         = strap_ff;
	assign deviceReady      = running;

	AST_REGS_CLEARED: assert property (@(posedge clk) disable iff (!nrst || !ce)
		hwRstActive |=> (pinIsIrq_ff == 1'b0) && (mask_ff == '0) && (status_ff == '0) && !regulatorOff)
		else $error("registers not cleared by hardware reset");

	AST_SEQ_AFTER_RESET: assert property (@(posedge clk) disable iff (!nrst || !ce)
		$fell(hwRstActive) |=> (state_ff == prps_pkg::SEQ_SAMPLE) ##1 deviceReady)
		else $error("reset sequence did not complete after release");

	AST_STRAP_LATCH: assert property (@(posedge clk) disable iff (!nrst || !ce)
		(state_ff == prps_pkg::SEQ_SAMPLE) && !hwRstActive |=> (strapCfg == $past(strapIn)))
		else $error("straps not captured at reset release");

	AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (!nrst || !ce)
		running && !hwRstActive |=> $stable(strapCfg))
		else $error("strap options changed while running");

	AST_PIN_ROLE: assert property (@(posedge clk) disable iff (!nrst || !ce)
		wrPin && !clrRegs |=> (pinIsIrq_ff == $past(avlReq.writedata[prps_pkg::PINCFG_IRQ_BIT])))
		else $error("pin role not taken from register write");

	AST_DEFAULT_PWDN: assert property (@(posedge clk) disable iff (!nrst || !ce)
		(state_ff == prps_pkg::SEQ_SAMPLE) |-> !pinIsIrq_ff && irqOrSleepPinOeN)
		else $error("shared pin not in power-down role after reset");

	AST_PWDN_ENTER: assert property (@(posedge clk) disable iff (!nrst || !ce)
		running && !hwRstActive && !pinIsIrq_ff && !irqOrSleepPinIn |=> powerDown)
		else $error("power-down not entered on low pin");

	AST_IRQ_DRIVE: assert property (@(posedge clk) disable iff (!nrst || !ce)
		pinIsIrq_ff && !clrRegs && (|(status_ff & mask_ff)) |=> pinIsIrq_ff |-> !irqOrSleepPinOeN)
		else $error("interrupt pin not pulled low");

	AST_NO_DRIVE_PWDN: assert property (@(posedge clk) disable iff (!nrst || !ce)
		!pinIsIrq_ff |-> irqOrSleepPinOeN && !irqOrSleepPinOut)
		else $error("shared pin driven in power-down role");

	AST_REG_OFF: assert property (@(posedge clk) disable iff (!nrst || !ce)
		wrAccept && hitPwr && be0 && !clrRegs |=> regulatorOff == $past(avlReq.writedata[prps_pkg::REGPWR_OFF_BIT]))
		else $error("regulator control write not applied");

	AST_IRQ_RELEASE: assert property (@(posedge clk) disable iff (!nrst || !ce)
		((status_ff & mask_ff) == '0) |=> !irq && irqOrSleepPinOeN)
		else $error("interrupt held with nothing pending");

	AST_AVL_ONE_WAIT: assert property (@(posedge clk) disable iff (!nrst || !ce)
		req && !ack_ff |=> (req |-> !avlWaitrequest))
		else $error("bus answer not given after one wait state");

	AST_AVL_ACK_PULSE: assert property (@(posedge clk) disable iff (!nrst || !ce)
		ack_ff |=> !ack_ff)
		else $error("bus acknowledge held longer than one cycle");

	AST_RDATA_LOAD: assert property (@(posedge clk) disable iff (!nrst || !ce)
		avlReq.read && !ack_ff |=> (avlReaddata == $past(rdMux)))
		else $error("read data not loaded from the addressed register");

	AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!nrst || !ce)
		!(avlReq.read && !ack_ff) |=> $stable(avlReaddata))
		else $error("read data changed without a read");

	AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (!nrst || !ce)
		avlReq.read && !ack_ff && !(hitPin || hitStat || hitMask || hitState || hitPwr) |=>
			(avlReaddata == prps_pkg::RDATA_NONE))
		else $error("unmapped read returned data");

	AST_STATUS_SET_WINS: assert property (@(posedge clk) disable iff (!nrst || !ce)
		!clrRegs && (irqEvent != '0) |=> ((status_ff & $past(irqEvent)) == $past(irqEvent)))
		else $error("interrupt event lost against a status clear");

	AST_STATUS_W1C: assert property (@(posedge clk) disable iff (!nrst || !ce)
		wrStat && !clrRegs && (irqEvent == '0) |=> ((status_ff & $past(clrMask)) == '0))
		else $error("status bit not cleared by writing one");

	AST_STATUS_STICKY: assert property (@(posedge clk) disable iff (!nrst || !ce)
		!clrRegs && !wrStat |=> ((status_ff & $past(status_ff)) == $past(status_ff)))
		else $error("status bit dropped without a clear");

	AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!nrst || !ce)
		wrMask && !clrRegs |=> (mask_ff == $past(avlReq.writedata[IRQ_W-1:0])))
		else $error("mask write not applied");

	AST_IRQ_FOLLOW: assert property (@(posedge clk) disable iff (!nrst || !ce)
		(|(status_ff & mask_ff)) |=> irq)
		else $error("interrupt not raised for an enabled event");

	AST_PWDN_ONLY_RUN: assert property (@(posedge clk) disable iff (!nrst || !ce)
		!running |=> !powerDown)
		else $error("power-down outside the running state");

	AST_PWDN_IRQ_ROLE: assert property (@(posedge clk) disable iff (!nrst || !ce)
		pinIsIrq_ff |=> !powerDown)
		else $error("power-down taken in interrupt role");

	AST_PWDN_EXIT: assert property (@(posedge clk) disable iff (!nrst || !ce)
		irqOrSleepPinIn |=> !powerDown)
		else $error("power-down held with the pin high");

	AST_HOLD_NOT_READY: assert property (@(posedge clk) disable iff (!nrst || !ce)
		hwRstActive |=> !deviceReady)
		else $error("device ready during hardware reset");

	AST_STRAP_TRACK: assert property (@(posedge clk) disable iff (!nrst || !ce)
		(state_ff == prps_pkg::SEQ_HOLD) |=> (strapCfg == $past(strapIn)))
		else $error("straps not sampled while reset holds");

	AST_REG_HIGH_BYTE: assert property (@(posedge clk) disable iff (!nrst || !ce)
		wrAccept && hitPwr && !be0 && !clrRegs |=> $stable(regulatorOff))
		else $error("regulator control changed by an upper byte write");

	AST_CLR_ON_HOLD: assert property (@(posedge clk) disable iff (!nrst || !ce)
		clrRegs |=> !regulatorOff && !pinIsIrq_ff && (mask_ff == '0) && (status_ff == '0))
		else $error("registers not cleared while the sequence holds");

	CVR_RESET_DONE: cover property (@(posedge clk) disable iff (!nrst) $fell(hwRstActive) ##2 deviceReady);
	CVR_IRQ_PIN:    cover property (@(posedge clk) disable iff (!nrst) pinIsIrq_ff && !irqOrSleepPinOeN);
	CVR_PWDN:       cover property (@(posedge clk) disable iff (!nrst) $rose(powerDown));
	CVR_REG_OFF:    cover property (@(posedge clk) disable iff (!nrst) $rose(regulatorOff));
	CVR_BUS_READ:   cover property (@(posedge clk) disable iff (!nrst) avlReq.read && !avlWaitrequest);

endmodule
`default_nettype wire

// ==== testbench/prps_host_model.sv ====
// Host controller model driving hardware reset and the shared pin
`timescale 1ns/100ps
`default_nettype none
module prps_host_model (
	input  wire logic clk,      // Device clock
	input  wire logic pinOut,   // Device pin drive value
	input  wire logic pinOeN,   // Device pin enable, low drives
	output var  logic hwResetN, // Hardware reset pin
	output wire logic pinLevel  // Resolved shared pin
);
	logic sleepLow;
	initial begin
		hwResetN = 1'b1;
		sleepLow = 1'b0;
	end
	// Weak pull-up wins unless someone pulls low
	assign pinLevel = ((!pinOeN && !pinOut) || sleepLow) ? 1'b0 : 1'b1;
	task automatic pulse_reset(input int n);
		@(posedge clk);
		hwResetN <= 1'b0;
		repeat (n) @(posedge clk);
		hwResetN <= 1'b1;
	endtask
	task automatic drive_sleep(input logic on);
		@(posedge clk);
		sleepLow <= on;
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the reset and power-down sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic                    clk = 1'b0;
	logic                    nrst = 1'b0;
	logic                    ce = 1'b1;
	logic [3:0]              busBe = 4'hF;
	logic [4:0]              strapIn = 5'h15;
	logic [3:0]              irqEvent = 4'h0;
	prps_pkg::prps_avl_req_s avlReq = '0;
	logic [31:0]             avlReaddata;
	logic [31:0]             rd;
	logic [4:0]              strapCfg;
	logic                    avlWaitrequest, pinOut, pinOeN, pinLevel, hwResetN;
	logic                    deviceReady, powerDown, regulatorOff, irq;
	int                      fails = 0;
	int                      n_checks = 0;

	always #50 clk = ~clk;

	prps_host_model host (.clk(clk), .pinOut(pinOut), .pinOeN(pinOeN), .hwResetN(hwResetN), .pinLevel(pinLevel));
	prps_sequencer dut (.clk(clk), .nrst(nrst), .ce(ce), .hwResetN(hwResetN),
		.strapIn(strapIn), .irqEvent(irqEvent), .irqOrSleepPinIn(pinLevel), .irqOrSleepPinOut(pinOut),
		.irqOrSleepPinOeN(pinOeN), .avlReq(avlReq), .avlReaddata(avlReaddata), .avlWaitrequest(avlWaitrequest),
		.strapCfg(strapCfg), .deviceReady(deviceReady), .powerDown(powerDown), .regulatorOff(regulatorOff), .irq(irq));

	task automatic stop_test();
		if (fails == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Holds the request until waitrequest is sampled low at a rising edge; data taken at that edge
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int i;
		@(posedge clk);
		avlReq <= '{read: !wr, write: wr, address: addr, writedata: data, byteenable: busBe};
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (avlWaitrequest === 1'b0) begin
				break;
			end
		end
		rd = avlReaddata;
		avlReq <= '0;
		if (i == 50) begin
			fails++;
			stop_test();
		end
	endtask
	task automatic wait_ready();
		int i;
		for (i = 0; i < 100 && deviceReady !== 1'b1; i++) @(posedge clk);
		check(32'(deviceReady), 32'h1);
		if (i == 100) begin
			stop_test();
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	initial begin
		wait_cyc(12);
		nrst <= 1'b1;
		wait_ready();
		bus(1'b0, prps_pkg::OFF_PINCFG, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, prps_pkg::OFF_REGPWR, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, 8'h40, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, prps_pkg::OFF_STATE, 32'h0);
		check(rd, 32'h0000_1501);
		strapIn <= 5'h0A;
		// Power-down role follows the host level
		host.drive_sleep(1'b1);
		wait_cyc(2);
		check(32'(powerDown), 32'h1);
		check(32'(strapCfg), 32'h15);
		host.drive_sleep(1'b0);
		bus(1'b1, prps_pkg::OFF_REGPWR, 32'h1);
		wait_cyc(1);
		check(32'(regulatorOff), 32'h1);
		bus(1'b0, prps_pkg::OFF_REGPWR, 32'h0);
		check(rd, 32'h1);
		// Upper byte alone must leave the regulator bit untouched
		busBe <= 4'h2;
		bus(1'b1, prps_pkg::OFF_REGPWR, 32'h0000_FF00);
		busBe <= 4'hF;
		bus(1'b0, prps_pkg::OFF_REGPWR, 32'h0);
		check(rd, 32'h0000_FF01);
		// Interrupt role, masked then enabled
		bus(1'b1, prps_pkg::OFF_PINCFG, 32'h1);
		bus(1'b1, prps_pkg::OFF_MASK, 32'h0);
		@(posedge clk);
		irqEvent <= 4'h1;
		@(posedge clk);
		irqEvent <= 4'h0;
		wait_cyc(3);
		check(32'(irq), 32'h0);
		check(32'(pinLevel), 32'h1);
		bus(1'b0, prps_pkg::OFF_STATUS, 32'h0);
		check(rd, 32'h1);
		bus(1'b1, prps_pkg::OFF_MASK, 32'h1);
		wait_cyc(3);
		check(32'(irq), 32'h1);
		check(32'(pinLevel), 32'h0);
		bus(1'b0, prps_pkg::OFF_STATE, 32'h0);
		check(rd, 32'h0000_150D);
		bus(1'b1, prps_pkg::OFF_STATUS, 32'h1);
		wait_cyc(2);
		check(32'(irq), 32'h0);
		check(32'(pinLevel), 32'h1);
		// Clock enable low freezes state, so this event is lost
		ce <= 1'b0;
		irqEvent <= 4'h2;
		wait_cyc(1);
		ce <= 1'b1;
		irqEvent <= 4'h0;
		bus(1'b0, prps_pkg::OFF_STATUS, 32'h0);
		check(rd, 32'h0);
		// Too short a pulse leaves state alone
		host.pulse_reset(5);
		wait_cyc(5);
		check(32'(regulatorOff), 32'h1);
		check(32'(deviceReady), 32'h1);
		host.pulse_reset(10);
		wait_cyc(2);
		check(32'(deviceReady), 32'h0);
		wait_ready();
		check(32'(regulatorOff), 32'h0);
		check(32'(strapCfg), 32'h0A);
		bus(1'b0, prps_pkg::OFF_PINCFG, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, prps_pkg::OFF_MASK, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, prps_pkg::OFF_REGPWR, 32'h0);
		check(rd, 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire
